// ---- common/qdl_pkg.sv ----
// shared constants for the quad converter serial load controller
package qdl_pkg;
  // ---------------------------------------------------------------
  // register map (axi4-lite byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_DATA = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_DIV = 4'hC;
  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int CODE_LSB = 0;
  localparam int CHAN_LSB = 16;
  localparam int LOAD_BIT = 18;
  localparam int UPD_BIT = 19;
  localparam int CTRL_UPD = 0;
  localparam int CTRL_RST = 1;
  localparam int CTRL_RSEL = 2;
  localparam int CTRL_HOLD = 3;
  localparam int STAT_BUSY = 0;
  localparam logic [7:0] DIV_RESET = 8'h10;
  localparam logic [7:0] DIV_MIN = 8'h04;
  // ---------------------------------------------------------------
  // timing, ns and derived 200 MHz cycles (least times round up)
  // ---------------------------------------------------------------
  localparam int CLK_NS = 5;
  localparam int T_LD2_NS = 15;
  localparam int T_LD1_NS = 40;
  localparam int T_LDRW_NS = 45;
  localparam int T_LDDW_NS = 45;
  localparam int T_RSSH_NS = 25;
  localparam int T_RSTW_NS = 70;
  localparam int T_CSS_NS = 55;
  localparam int T_CSH_NS = 15;
  localparam int CYC_LD2 = (T_LD2_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_LD1 = (T_LD1_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_LDRW = (T_LDRW_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_LDDW = (T_LDDW_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_RSSH = (T_RSSH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_RSTW = (T_RSTW_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_CSS = (T_CSS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_CSH = (T_CSH_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 8;
endpackage

// ---- dv/qdl_dev_model.sv ----
// behavioural model of the quad converter digital load logic
`timescale 1ns/1ps
module qdl_dev_model (
  input wire logic serial_in,
  input wire logic serial_clk,
  input wire logic chip_sel_n,
  input wire logic input_latch_strobe_n,
  input wire logic output_update_strobe_n,
  input wire logic dev_reset_n,
  input wire logic reset_value_select,
  output logic [47:0] in_codes,
  output logic [47:0] out_codes
);
  // ---------------------------------------------------------------
  // shift path
  // ---------------------------------------------------------------
  logic [15:0] shreg_ff;
  logic [11:0] rst_code;
  wire shift_clk = chip_sel_n | serial_clk;
  assign rst_code = reset_value_select ? 12'h800 : 12'h000;
  // no reset term and no bit count: loads use whatever sits here
  always_ff @(posedge shift_clk) begin
    shreg_ff <= {shreg_ff[14:0], serial_in};
  end
  // ---------------------------------------------------------------
  // latches
  // ---------------------------------------------------------------
  // top two bits pick the latch, bits 13:12 are never looked at
  always_latch begin
    if (!dev_reset_n) begin
      in_codes <= {4{rst_code}};
    end else if (!input_latch_strobe_n) begin
      in_codes[shreg_ff[15:14]*12 +: 12] <= shreg_ff[11:0];
    end
  end
  // transparent while update low, so loads show at once in hold mode
  always_latch begin
    if (!dev_reset_n) begin
      out_codes <= {4{rst_code}};
    end else if (!output_update_strobe_n) begin
      out_codes <= in_codes;
    end
  end
endmodule

// ---- dv/qdl_host_props.sv ----
// pin timing and handshake assertions for the load controller
`timescale 1ns/1ps
module qdl_host_props (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_in,
  input wire logic serial_clk,
  input wire logic chip_sel_n,
  input wire logic input_latch_strobe_n,
  input wire logic output_update_strobe_n,
  input wire logic dev_reset_n,
  input wire logic reset_value_select
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // ---------------------------------------------------------------
  // age counters, saturating so long idle stretches stay legal
  // ---------------------------------------------------------------
  logic [7:0] clk_age_ff;
  logic [7:0] ld_age_ff;
  logic [7:0] sel_age_ff;
  always_ff @(posedge core_clk) begin
    if (srst) clk_age_ff <= 8'hFF;
    else if ($rose(serial_clk)) clk_age_ff <= 8'h00;
    else if (clk_age_ff != 8'hFF) clk_age_ff <= clk_age_ff + 8'h01;
  end
  always_ff @(posedge core_clk) begin
    if (srst) ld_age_ff <= 8'hFF;
    else if ($rose(input_latch_strobe_n)) ld_age_ff <= 8'h00;
    else if (ld_age_ff != 8'hFF) ld_age_ff <= ld_age_ff + 8'h01;
  end
  always_ff @(posedge core_clk) begin
    if (srst) sel_age_ff <= 8'hFF;
    else if ($changed(reset_value_select)) sel_age_ff <= 8'h00;
    else if (sel_age_ff != 8'hFF) sel_age_ff <= sel_age_ff + 8'h01;
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence s_rst_low14;
    !dev_reset_n[*8] ##1 !dev_reset_n[*6];
  endsequence
  sequence s_ld_low9;
    !input_latch_strobe_n ##1 !input_latch_strobe_n[*8];
  endsequence
  AST_CS_RISE_CLK_HIGH: assert property ($rose(chip_sel_n) |->
    serial_clk && $past(serial_clk)) else $error("cs rose, clk low");
  AST_LOAD_HIGH_SHIFT: assert property (!chip_sel_n |->
    input_latch_strobe_n) else $error("load low while selected");
  AST_LOAD_CS_HIGH: assert property (!input_latch_strobe_n |->
    chip_sel_n) else $error("load pulse with cs low");
  AST_RESET_CS_HIGH: assert property (!dev_reset_n |-> chip_sel_n)
    else $error("reset pulse with cs low");
  AST_LOAD_WIDTH: assert property ($fell(input_latch_strobe_n) |->
    s_ld_low9) else $error("load pulse too short");
  AST_UPD_WIDTH: assert property ($fell(output_update_strobe_n) |=>
    !output_update_strobe_n[*8]) else $error("update pulse too short");
  AST_RST_WIDTH: assert property ($fell(dev_reset_n) |-> s_rst_low14)
    else $error("reset pulse too short");
  AST_SEL_SETUP: assert property ($fell(dev_reset_n) |->
    sel_age_ff >= 8'h04) else $error("select changed near reset");
  AST_LD_AFTER_CLK: assert property ($fell(input_latch_strobe_n) |->
    clk_age_ff >= 8'h02) else $error("load too soon after clk");
  AST_LD_BEFORE_CLK: assert property ($rose(serial_clk) &&
    !chip_sel_n |-> ld_age_ff >= 8'h07) else $error("clk too soon");
  AST_DATA_SETUP: assert property ($rose(serial_clk) |->
    $stable(serial_in)) else $error("data moved at clk rise");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("bvalid dropped early");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid) else $error("rvalid dropped early");
  COV_RESET: cover property ($fell(dev_reset_n));
endmodule

// ---- dv/test_qdl_host.sv ----
// self-checking bench for the load controller with a device model
`timescale 1ns/1ps
module test_qdl_host import qdl_pkg::*;;
  logic core_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, serial_in;
  logic serial_clk, chip_sel_n, input_latch_strobe_n, dev_reset_n;
  logic output_update_strobe_n, reset_value_select;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [47:0] in_codes, out_codes, ein, eout;
  logic [15:0] rnd;
  logic [11:0] c;
  logic [32:0] e;
  logic [1:0] bq[$];
  logic [32:0] rq[$];
  logic [1:0] rsq[$];
  int n_mismatch, num_checks, i;
  qdl_host DUT (.core_clk, .srst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .serial_in, .serial_clk,
    .chip_sel_n, .input_latch_strobe_n, .output_update_strobe_n,
    .dev_reset_n, .reset_value_select);
  qdl_dev_model u_dev (.serial_in, .serial_clk, .chip_sel_n,
    .input_latch_strobe_n, .output_update_strobe_n, .dev_reset_n,
    .reset_value_select, .in_codes, .out_codes);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] word(input int ch, input logic [11:0] v,
                                       input logic u);
    return (32'(ch) << CHAN_LSB) | (32'h1 << LOAD_BIT) |
           (32'(u) << UPD_BIT) | {20'h0, v};
  endfunction
  task conclude();
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [47:0] seen, input logic [47:0] x);
    num_checks++;
    if (seen !== x) begin
      $display("Error %s expected %h seen %h", nm, x, seen);
      n_mismatch++;
    end
  endtask
  // write: both channels offered together, each dropped when taken
  task wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    int n;
    bq.push_back(r);
    @(posedge core_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    conclude();
  endtask
  // read: bit 32 of the note marks a poll whose value is not compared
  task rd(input logic [3:0] a, input logic [32:0] x, output logic [31:0] v);
    int n;
    rq.push_back(x);
    // only aligned words are mapped, anything else answers slverr
    rsq.push_back((a[1:0] == 2'b00) ? 2'b00 : 2'b10);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    conclude();
  endtask
  task wait_idle();
    int k;
    for (k = 0; k < 400; k++) begin
      rd(REG_STAT, 33'h1_0000_0000, d);
      if (d[STAT_BUSY] === 1'b0) return;
    end
    n_mismatch++;
    conclude();
  endtask
  // ---------------------------------------------------------------
  // response monitor, oldest note first
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      chk("bresp", 48'(s_axi_bresp), 48'(bq.pop_front()));
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      e = rq.pop_front();
      chk("rresp", 48'(s_axi_rresp), 48'(rsq.pop_front()));
      if (e[32] === 1'b0) chk("rdata", 48'(s_axi_rdata), 48'(e[31:0]));
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    srst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    rnd = 16'h0028;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    rd(REG_DIV, {25'h0, DIV_RESET}, d);
    rd(REG_STAT, 33'h0, d);
    // unaligned address refused, data word reads back as zero
    wr(4'h2, 32'h0000_0000, 2'b10);
    rd(4'h2, 33'h0, d);
    rd(REG_DATA, 33'h0, d);
    // mid-scale then zero-scale reset of every latch
    for (i = 1; i >= 0; i--) begin
      c = (i == 1) ? 12'h800 : 12'h000;
      wr(REG_CTRL, (32'(i) << CTRL_RSEL) | (32'h1 << CTRL_RST), 2'b00);
      wait_idle();
      rd(REG_CTRL, 33'(i) << CTRL_RSEL, d);
      ein = {4{c}};
      eout = ein;
      chk("in_codes", in_codes, ein);
      chk("out_codes", out_codes, eout);
    end
    // a too short half period is raised to the minimum
    wr(REG_DIV, 32'h0000_0001, 2'b00);
    rd(REG_DIV, 33'(DIV_MIN), d);
    wr(REG_DIV, 32'(DIV_MIN), 2'b00);
    rd(REG_DIV, 33'(DIV_MIN), d);
    // load each channel, outputs must hold until the update
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      ein[i*12 +: 12] = rnd[11:0];
      wr(REG_DATA, word(i, rnd[11:0], 1'b0), 2'b00);
      if (i == 0) wr(REG_DATA, word(1, 12'hFFF, 1'b0), 2'b10);
      wait_idle();
      chk("in_codes", in_codes, ein);
      chk("out_codes", out_codes, eout);
    end
    wr(REG_CTRL, 32'h1 << CTRL_UPD, 2'b00);
    wait_idle();
    eout = ein;
    chk("out_codes", out_codes, eout);
    // hold mode: a load reaches its output at once
    wr(REG_CTRL, 32'h1 << CTRL_HOLD, 2'b00);
    wait_idle();
    rd(REG_CTRL, 33'(32'h1 << CTRL_HOLD), d);
    rnd = lfsr(rnd);
    ein[24 +: 12] = rnd[11:0];
    eout = ein;
    wr(REG_DATA, word(2, rnd[11:0], 1'b0), 2'b00);
    wait_idle();
    chk("out_codes", out_codes, eout);
    wr(REG_CTRL, 32'h0, 2'b00);
    wait_idle();
    rnd = lfsr(rnd);
    ein[36 +: 12] = rnd[11:0];
    eout = ein;
    wr(REG_DATA, word(3, rnd[11:0], 1'b1), 2'b00);
    wait_idle();
    chk("out_codes", out_codes, eout);
    conclude();
  end
endmodule
bind qdl_host qdl_host_props u_props (.core_clk, .srst, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .serial_in, .serial_clk,
  .chip_sel_n, .input_latch_strobe_n, .output_update_strobe_n,
  .dev_reset_n, .reset_value_select);

// ---- verilog/qdl_clkdiv.sv ----
// serial clock rate divider producing one-cycle tick pulses
`timescale 1ns/1ps
module qdl_clkdiv import qdl_pkg::*; (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [7:0] half_period,
  output logic tick
);
  logic [7:0] cnt_ff;
  // ---------------------------------------------------------------
  // counter restarts whenever idle so the first half phase is full
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst || !run) begin
      cnt_ff <= 8'h00;
      tick <= 1'b0;
    end else if (cnt_ff >= half_period - 8'h01) begin
      cnt_ff <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule

// ---- verilog/qdl_host.sv ----
// axi4-lite controlled host driving the quad converter load pins
// Contract
// - each transfer is one 16-bit word
// - 12-bit code follows, msb first
// - update strobe falling moves all latches
// - raise chip select only with clock high
// - load strobe high while shifting
// - chip select high during strobe pulses
// - load strobe low 15 ns after last edge
// - load strobe high 40 ns before next word
// - select pin stable 25 ns before reset
`timescale 1ns/1ps
module qdl_host import qdl_pkg::*; (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [3:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic serial_in,
  output logic serial_clk,
  output logic chip_sel_n,
  output logic input_latch_strobe_n,
  output logic output_update_strobe_n,
  output logic dev_reset_n,
  output logic reset_value_select
);
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_CSS = 9'h002,
    ST_LOW = 9'h004,
    ST_HIGH = 9'h008,
    ST_CSH = 9'h010,
    ST_LDGAP = 9'h020,
    ST_LOAD = 9'h040,
    ST_UPD = 9'h080,
    ST_RST = 9'h100
  } qdl_state_t;
  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  qdl_state_t state_ff, nxt_state;
  logic [WORD_BITS-1:0] shift_ff;
  logic [4:0] bits_ff;
  logic [7:0] div_ff;
  logic hold_ff, rsel_ff;
  logic job_ff, job_load_ff, job_upd_ff, job_rst_ff;
  logic [WORD_BITS-1:0] job_word_ff;
  logic post_rst_ff;
  logic aw_ff, w_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic tick, tmr_load, tmr_done;
  logic [TMR_W-1:0] tmr_count;
  logic wr_go, busy;
  logic [31:0] rd_val;
  assign busy = (state_ff != ST_IDLE) || job_ff;
  // ---------------------------------------------------------------
  // write channel: address and data taken in either order
  // ---------------------------------------------------------------
  assign wr_go = aw_ff && w_ff && !s_axi_bvalid;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_ff <= 1'b0;
    end else begin
      s_axi_awready <= !aw_ff && !s_axi_awready;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      w_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_ff <= 1'b0;
    end else begin
      s_axi_wready <= !w_ff && !s_axi_wready;
    end
  end
  // response: slverr for a busy data or control write or unmapped address
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_ff == REG_DATA || awaddr_ff == REG_CTRL) begin
        s_axi_bresp <= busy ? 2'h2 : 2'h0;
      end else if (awaddr_ff == REG_DIV || awaddr_ff == REG_STAT) begin
        s_axi_bresp <= 2'h0;
      end else begin
        s_axi_bresp <= 2'h2;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // software registers and job capture
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_ff <= DIV_RESET;
      hold_ff <= 1'b0;
      rsel_ff <= 1'b0;
    end else if (wr_go && awaddr_ff == REG_DIV && s_axi_wstrb[0]) begin
      div_ff <= (wdata_ff[7:0] < DIV_MIN) ? DIV_MIN : wdata_ff[7:0];
    end else if (wr_go && awaddr_ff == REG_CTRL && !busy &&
                 s_axi_wstrb[0]) begin
      hold_ff <= wdata_ff[CTRL_HOLD];
      rsel_ff <= wdata_ff[CTRL_RSEL];
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      job_ff <= 1'b0;
      job_load_ff <= 1'b0;
      job_upd_ff <= 1'b0;
      job_rst_ff <= 1'b0;
      job_word_ff <= '0;
    end else if (wr_go && !busy && awaddr_ff == REG_DATA) begin
      job_ff <= 1'b1;
      job_rst_ff <= 1'b0;
      job_load_ff <= wdata_ff[LOAD_BIT];
      job_upd_ff <= wdata_ff[UPD_BIT];
      // channel first, two zero spare bits, code msb first
      job_word_ff <= {wdata_ff[CHAN_LSB +: 2], 2'b00,
                      wdata_ff[CODE_LSB +: CODE_BITS]};
    end else if (wr_go && !busy && awaddr_ff == REG_CTRL) begin
      job_ff <= wdata_ff[CTRL_UPD] | wdata_ff[CTRL_RST];
      job_rst_ff <= wdata_ff[CTRL_RST];
      job_upd_ff <= wdata_ff[CTRL_UPD];
      job_load_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && job_ff) begin
      job_ff <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // read channel, one cycle from address to data
  // ---------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      REG_CTRL: begin
        rd_val[CTRL_HOLD] = hold_ff;
        rd_val[CTRL_RSEL] = rsel_ff;
      end
      REG_STAT: rd_val[STAT_BUSY] = busy;
      REG_DIV: rd_val[7:0] = div_ff;
      default: rd_val = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= (s_axi_araddr == REG_DATA || s_axi_araddr == REG_CTRL
                      || s_axi_araddr == REG_STAT || s_axi_araddr == REG_DIV)
                     ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // pin sequencer
  // ---------------------------------------------------------------
  qdl_clkdiv u_div (
    .core_clk(core_clk),
    .srst(srst),
    .run(state_ff == ST_LOW || state_ff == ST_HIGH),
    .half_period(div_ff),
    .tick(tick)
  );
  qdl_timer u_tmr (
    .core_clk(core_clk),
    .srst(srst),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );
  always_comb begin
    nxt_state = state_ff;
    tmr_load = 1'b0;
    tmr_count = '0;
    unique case (state_ff)
      ST_IDLE: begin
        if (job_ff && job_rst_ff) begin
          nxt_state = ST_RST;
          tmr_load = 1'b1;
          tmr_count = TMR_W'(CYC_RSSH);
        end else if (job_ff && job_load_ff) begin
          nxt_state = ST_CSS;
          tmr_load = 1'b1;
          tmr_count = TMR_W'(CYC_CSS);
        end else if (job_ff && job_upd_ff) begin
          nxt_state = ST_UPD;
          tmr_load = 1'b1;
          tmr_count = TMR_W'(CYC_LDDW);
        end
      end
      ST_CSS: if (tmr_done) nxt_state = ST_LOW;
      ST_LOW: if (tick) nxt_state = ST_HIGH;
      ST_HIGH: begin
        if (tick && bits_ff == 5'd1) begin
          nxt_state = ST_CSH;
          tmr_load = 1'b1;
          tmr_count = TMR_W'(CYC_CSH);
        end else if (tick) begin
          nxt_state = ST_LOW;
        end
      end
      ST_CSH: begin
        if (tmr_done) begin
          nxt_state = ST_LDGAP;
          tmr_load = 1'b1;
          tmr_count = TMR_W'(CYC_LD2);
        end
      end
      ST_LDGAP: begin
        if (tmr_done) begin
          nxt_state = ST_LOAD;
          tmr_load = 1'b1;
          tmr_count = TMR_W'(CYC_LDRW);
        end
      end
      ST_LOAD: begin
        if (tmr_done) begin
          nxt_state = ST_LDGAP;
          tmr_load = 1'b1;
          tmr_count = TMR_W'(CYC_LD1);
        end
      end
      ST_UPD: begin
        if (tmr_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_RST: begin
        if (tmr_done && !post_rst_ff) begin
          nxt_state = ST_RST;
          tmr_load = 1'b1;
          tmr_count = TMR_W'(CYC_RSTW);
        end else if (tmr_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    // second gap after load, with the 40 ns margin, leads to the update or ends the job
    if (state_ff == ST_LDGAP && tmr_done && post_rst_ff) begin
      nxt_state = job_upd_ff ? ST_UPD : ST_IDLE;
      tmr_load = job_upd_ff;
      tmr_count = TMR_W'(CYC_LDDW);
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  // phase marker: reused for reset hold phase and post-load gap
  always_ff @(posedge core_clk) begin
    if (srst || state_ff == ST_IDLE) begin
      post_rst_ff <= 1'b0;
    end else if ((state_ff == ST_RST || state_ff == ST_LOAD) && tmr_done) begin
      post_rst_ff <= 1'b1;
    end
  end
  // shift data: bits change at the falling half, device samples rising
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shift_ff <= '0;
      bits_ff <= 5'd0;
      serial_in <= 1'b0;
    end else if (state_ff == ST_IDLE && job_ff && job_load_ff) begin
      shift_ff <= {job_word_ff[WORD_BITS-2:0], 1'b0};
      serial_in <= job_word_ff[WORD_BITS-1];
      bits_ff <= 5'(WORD_BITS);
    end else if (state_ff == ST_HIGH && tick && bits_ff != 5'd1) begin
      serial_in <= shift_ff[WORD_BITS-1];
      shift_ff <= {shift_ff[WORD_BITS-2:0], 1'b0};
      bits_ff <= bits_ff - 5'd1;
    end
  end
  // ---------------------------------------------------------------
  // pin drivers, all registered
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      serial_clk <= 1'b1;
      chip_sel_n <= 1'b1;
    end else begin
      // clock idles high so chip select never rises on a low clock
      serial_clk <= (nxt_state != ST_LOW);
      chip_sel_n <= !(nxt_state == ST_CSS || nxt_state == ST_LOW ||
                      nxt_state == ST_HIGH);
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      input_latch_strobe_n <= 1'b1;
      output_update_strobe_n <= 1'b1;
      dev_reset_n <= 1'b1;
      reset_value_select <= 1'b0;
    end else begin
      // load strobe only outside shifting
      input_latch_strobe_n <= (nxt_state != ST_LOAD);
      // hold mode keeps outputs transparent to each load
      output_update_strobe_n <= !(nxt_state == ST_UPD || hold_ff);
      dev_reset_n <= !(state_ff == ST_RST && nxt_state == ST_RST &&
                       (post_rst_ff || tmr_done));
      reset_value_select <= rsel_ff;
    end
  end
endmodule

// ---- verilog/qdl_timer.sv ----
// one-shot down counter for minimum pin phase times
`timescale 1ns/1ps
module qdl_timer import qdl_pkg::*; (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [TMR_W-1:0] count,
  output logic done
);
  logic [TMR_W-1:0] cnt_ff;
  // ---------------------------------------------------------------
  // done is high once count cycles have passed since load
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= count;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - {{(TMR_W-1){1'b0}}, 1'b1};
    end
  end
  // no load term: the sequencer reloads on done, so one would loop
  assign done = (cnt_ff == '0);
endmodule
